// file: hw/spd_pkg.sv
// constants and field layouts shared by the serial pixel deserializer
// Overview of operation
// RULE1 - one 30-bit shift register gathers each word from the enabled lanes
// RULE2 - after the parity check, 24 colour and 3 control bits go to the output bus
// RULE3 - a word with good parity leaves the parity error flag low
// RULE4 - a word with bad parity pulses the flag high and is discarded
// RULE5 - on bad parity the previous output word stays one more pixel period
// RULE6 - the bit clock is recovered from the incoming link clock
// RULE7 - each recovered bit clock shifts one bit per enabled lane
// RULE8 - a pixel clock is regenerated and each word is aligned to it
// RULE9 - without link clock: pixel clock and display enable low, others high; the parity error flag is driven low
// RULE10 - the swap select reverses the colour bit order on the output bus
// RULE11 - the two lane select bits choose one, two or three lanes
// RULE12 - receiver_on low enters shutdown, high leaves it
// RULE13 - a link clock that stops toggling puts the receiver in standby
// RULE14 - the transmitter enters standby by releasing its link clock
// RULE15 - lane b is used when exactly one lane select bit is high
// RULE16 - lane c is used only when select low is 0 and select high is 1
// RULE17 - the link clock has fixed polarity, no inversion option
// RULE18 - the payload and parity layout in the 30-bit word is fixed
// RULE19 - parity sense is fixed; the error pulse lasts one pixel clock period
package spd_pkg;
  localparam int WORD_BITS = 30;
  localparam int PAYLOAD_BITS = 27;
  localparam int COLOUR_BITS = 24;
  // position of fields inside the received 30-bit word, first bit received is bit 29
  localparam int POS_DEN = 3;
  localparam int POS_PARITY = 2;
  // position of fields inside a buffered entry {parity bad, colour, frame, line, enable}
  localparam int D_ERR = 27;
  localparam int D_COLOUR_LSB = 3;
  localparam int D_FSYNC = 2;
  localparam int D_LSYNC = 1;
  localparam int D_DEN = 0;
  localparam logic PARITY_ODD = 1'b1;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int LINK_IDLE_NS = 1000;
  localparam int LINK_IDLE_CYC = (LINK_IDLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PCLK_HALF_NS = 40;
  localparam int PCLK_HALF_CYC = (PCLK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // bits per lane for one word
  localparam logic [4:0] BPL_ONE = 5'h1e;
  localparam logic [4:0] BPL_TWO = 5'h0f;
  localparam logic [4:0] BPL_THREE = 5'h0a;
  // register map
  localparam int APB_AW = 8;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_ERRCNT = 8'h08;
  localparam int CTRL_RXON = 0;
  localparam int CTRL_LSLO = 1;
  localparam int CTRL_LSHI = 2;
  localparam int CTRL_SWAP = 3;
  localparam logic [31:0] CTRL_MASK = 32'h0000000f;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam int ST_ACTIVE = 0;
  localparam int ST_SHUTDOWN = 1;
  localparam int ST_OVERFLOW = 2;
  localparam int ST_LANES_LSB = 4;
  typedef enum logic [1:0] {OUT_OFF, OUT_WAIT, OUT_HIGH, OUT_LOW} spd_out_e;
endpackage

// file: hw/spd_fifo.sv
// word buffer between the deserializer and the pixel output stage
`timescale 1ns/1ps
module spd_fifo #(
  parameter int WIDTH = 28,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("spd_fifo depth must be a power of two of at least 2");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wrPtr;
    logic [AW:0] rdPtr;
  } spd_fifo_s;

  spd_fifo_s state_ff, nxt_state;

  always_comb begin
    nxt_state = state_ff;
    if (inValid && inReady) begin
      nxt_state.mem[state_ff.wrPtr[AW-1:0]] = inData;
      nxt_state.wrPtr = state_ff.wrPtr + 1'b1;
    end
    if (outValid && outReady) begin
      nxt_state.rdPtr = state_ff.rdPtr + 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= '0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // full when pointers differ only in the wrap bit
  assign inReady = (state_ff.wrPtr ^ state_ff.rdPtr) != {1'b1, {AW{1'b0}}};
  assign outValid = state_ff.wrPtr != state_ff.rdPtr;
  assign outData = state_ff.mem[state_ff.rdPtr[AW-1:0]];
endmodule

// file: hw/spd_receiver.sv
// serial pixel deserializer: lane capture, parity check, pixel output bus and APB registers
`timescale 1ns/1ps
module spd_receiver import spd_pkg::*; #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic linkClk,
  input wire logic serialLaneA,
  input wire logic serialLaneB,
  input wire logic serialLaneC,
  input wire logic sinkReady,
  output logic pixelClk,
  output logic [COLOUR_BITS-1:0] colourOut,
  output logic frameSync,
  output logic lineSync,
  output logic displayEnable,
  output logic parityErrorFlag,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  localparam int FW = PAYLOAD_BITS + 1;

  if (FIFO_DEPTH < 2) begin : g_chk
    $error("spd_receiver needs a buffer of at least two words");
  end

  typedef struct packed {
    logic [1:0] clkSync;
    logic [1:0][2:0] laneSync;
    logic clkPrev;
    logic [11:0] idleCnt;
    logic linkActive;
    logic [WORD_BITS-1:0] shiftReg;
    logic [4:0] bitCnt;
    logic pushValid;
    logic [FW-1:0] pushData;
    spd_out_e outState;
    logic [3:0] phaseCnt;
    logic [COLOUR_BITS-1:0] colour;
    logic fsync;
    logic lsync;
    logic den;
    logic perr;
    logic pclk;
    logic [31:0] ctrl;
    logic overflow;
    logic [15:0] errCnt;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } spd_rx_s;

  spd_rx_s state_ff, nxt_state;

  logic fifoInReady;
  logic fifoOutValid;
  logic fifoOutReady;
  logic [FW-1:0] fifoOutData;

  spd_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .inValid(state_ff.pushValid),
    .inReady(fifoInReady),
    .inData(state_ff.pushData),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  function automatic logic [COLOUR_BITS-1:0] reverseBits(input logic [COLOUR_BITS-1:0] v);
    logic [COLOUR_BITS-1:0] r;
    r = '0;
    for (int i = 0; i < COLOUR_BITS; i++) begin
      r[i] = v[COLOUR_BITS-1-i];
    end
    return r;
  endfunction

  logic linkRise;
  logic rxOn;
  logic swapSel;
  logic [1:0] laneSel;
  logic [4:0] bitsPerLane;
  logic [1:0] laneCount;
  logic active;
  logic capture;
  logic popBad;
  logic popGood;
  logic accessTaken;
  logic [WORD_BITS-1:0] shifted;

  assign linkRise = state_ff.clkSync[1] & ~state_ff.clkPrev; // RULE17
  assign rxOn = state_ff.ctrl[CTRL_RXON];
  assign swapSel = state_ff.ctrl[CTRL_SWAP];
  assign laneSel = {state_ff.ctrl[CTRL_LSHI], state_ff.ctrl[CTRL_LSLO]};
  assign active = rxOn & state_ff.linkActive;
  // the edge that wakes the link already carries the first bit of a word
  assign capture = rxOn & (state_ff.linkActive | linkRise); // RULE1
  assign fifoOutReady = (state_ff.outState == OUT_WAIT) & active & sinkReady;
  assign popBad = fifoOutReady & fifoOutValid & fifoOutData[D_ERR];
  assign popGood = fifoOutReady & fifoOutValid & ~fifoOutData[D_ERR];
  assign accessTaken = psel & penable & state_ff.pready;

  // lane b joins when exactly one select bit is high, lane c only for select high alone
  always_comb begin
    case (laneSel) // RULE11
      2'b01: begin
        laneCount = 2'd2; // RULE15
        bitsPerLane = BPL_TWO;
      end
      2'b10: begin
        laneCount = 2'd3; // RULE16
        bitsPerLane = BPL_THREE;
      end
      default: begin
        laneCount = 2'd1;
        bitsPerLane = BPL_ONE;
      end
    endcase
  end

  // lane a carries the earliest bit of each group
  always_comb begin
    case (laneCount)
      2'd2: shifted = {state_ff.shiftReg[WORD_BITS-3:0], state_ff.laneSync[1][0], state_ff.laneSync[1][1]};
      2'd3: shifted = {state_ff.shiftReg[WORD_BITS-4:0], state_ff.laneSync[1][0], state_ff.laneSync[1][1],
                       state_ff.laneSync[1][2]};
      default: shifted = {state_ff.shiftReg[WORD_BITS-2:0], state_ff.laneSync[1][0]};
    endcase
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_state.clkSync[0] = linkClk;
    nxt_state.clkSync[1] = state_ff.clkSync[0];
    nxt_state.laneSync[0] = {serialLaneC, serialLaneB, serialLaneA};
    nxt_state.laneSync[1] = state_ff.laneSync[0];
    nxt_state.clkPrev = state_ff.clkSync[1];
    nxt_state.pushValid = 1'b0;
    // each rising link edge stands in for one recovered bit clock tick; the edge timer doubles as lock detect
    if (!rxOn) begin
      nxt_state.linkActive = 1'b0; // RULE12
      nxt_state.idleCnt = '0;
    end else if (linkRise) begin
      nxt_state.linkActive = 1'b1; // RULE6
      nxt_state.idleCnt = '0;
    end else if (state_ff.idleCnt == 12'(LINK_IDLE_CYC - 1)) begin
      nxt_state.linkActive = 1'b0; // RULE13
    end else begin
      nxt_state.idleCnt = state_ff.idleCnt + 1'b1;
    end
    // word framing restarts whenever the link comes back, so words line up with the first edge
    if (!capture) begin
      nxt_state.bitCnt = '0;
    end else if (linkRise) begin
      nxt_state.shiftReg = shifted; // RULE7
      if (state_ff.bitCnt == bitsPerLane - 5'd1) begin
        nxt_state.bitCnt = '0; // RULE1
        nxt_state.pushValid = 1'b1;
        nxt_state.pushData = {(^shifted[WORD_BITS-1:POS_PARITY]) ^ PARITY_ODD,
                              shifted[WORD_BITS-1:POS_DEN]}; // RULE18 RULE19
      end else begin
        nxt_state.bitCnt = state_ff.bitCnt + 5'd1;
      end
    end
    // register access; hardware sets below win over a clear in the same cycle
    nxt_state.pready = psel & penable & ~state_ff.pready;
    nxt_state.prdata = '0;
    nxt_state.pslverr = 1'b0;
    if (psel && penable && !state_ff.pready) begin
      case (paddr)
        ADDR_CTRL: nxt_state.prdata = state_ff.ctrl;
        ADDR_STATUS: begin
          nxt_state.prdata[ST_ACTIVE] = state_ff.linkActive;
          nxt_state.prdata[ST_SHUTDOWN] = ~rxOn;
          nxt_state.prdata[ST_OVERFLOW] = state_ff.overflow;
          nxt_state.prdata[ST_LANES_LSB +: 2] = laneCount;
        end
        ADDR_ERRCNT: nxt_state.prdata[15:0] = state_ff.errCnt;
        default: nxt_state.pslverr = 1'b1;
      endcase
    end
    if (accessTaken && pwrite) begin
      case (paddr)
        ADDR_CTRL: nxt_state.ctrl = pwdata & CTRL_MASK;
        ADDR_STATUS: begin
          if (pwdata[ST_OVERFLOW]) begin
            nxt_state.overflow = 1'b0;
          end
        end
        ADDR_ERRCNT: nxt_state.errCnt = '0;
        default: ;
      endcase
    end
    // a word that finds the buffer full is lost and reported
    if (state_ff.pushValid && !fifoInReady) begin
      nxt_state.overflow = 1'b1;
    end
    if (popBad && state_ff.errCnt != 16'hffff) begin
      nxt_state.errCnt = nxt_state.errCnt + 16'h0001;
    end
    // pixel output stage: one regenerated pixel clock period per buffered word
    case (state_ff.outState)
      OUT_OFF: begin
        if (active) begin
          nxt_state.outState = OUT_WAIT;
        end
      end
      OUT_WAIT: begin
        if (!active) begin
          nxt_state.outState = OUT_OFF;
          nxt_state.pclk = 1'b0; // RULE9
          nxt_state.den = 1'b0;
          nxt_state.fsync = 1'b1;
          nxt_state.lsync = 1'b1;
          nxt_state.colour = '1;
          nxt_state.perr = 1'b0;
        end else if (fifoOutReady && fifoOutValid) begin
          nxt_state.pclk = 1'b1; // RULE8
          nxt_state.phaseCnt = '0;
          nxt_state.outState = OUT_HIGH;
          if (fifoOutData[D_ERR]) begin
            nxt_state.perr = 1'b1; // RULE4 RULE5
          end else begin
            nxt_state.perr = 1'b0; // RULE3
            nxt_state.colour = swapSel ? reverseBits(fifoOutData[D_COLOUR_LSB +: COLOUR_BITS]) :
                               fifoOutData[D_COLOUR_LSB +: COLOUR_BITS]; // RULE2 RULE10
            nxt_state.fsync = fifoOutData[D_FSYNC];
            nxt_state.lsync = fifoOutData[D_LSYNC];
            nxt_state.den = fifoOutData[D_DEN];
          end
        end
      end
      OUT_HIGH: begin
        if (state_ff.phaseCnt == 4'(PCLK_HALF_CYC - 1)) begin
          nxt_state.pclk = 1'b0;
          nxt_state.phaseCnt = '0;
          nxt_state.outState = OUT_LOW;
        end else begin
          nxt_state.phaseCnt = state_ff.phaseCnt + 4'd1;
        end
      end
      OUT_LOW: begin
        if (state_ff.phaseCnt == 4'(PCLK_HALF_CYC - 1)) begin
          nxt_state.perr = 1'b0; // RULE19
          nxt_state.outState = OUT_WAIT;
        end else begin
          nxt_state.phaseCnt = state_ff.phaseCnt + 4'd1;
        end
      end
      default: nxt_state.outState = OUT_OFF;
    endcase
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= '0;
      state_ff.colour <= '1;
      state_ff.fsync <= 1'b1;
      state_ff.lsync <= 1'b1;
      state_ff.ctrl <= CTRL_RESET;
      state_ff.outState <= OUT_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign pixelClk = state_ff.pclk;
  assign colourOut = state_ff.colour;
  assign frameSync = state_ff.fsync;
  assign lineSync = state_ff.lsync;
  assign displayEnable = state_ff.den;
  assign parityErrorFlag = state_ff.perr;
  assign prdata = state_ff.prdata;
  assign pready = state_ff.pready;
  assign pslverr = state_ff.pslverr;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  property p_err_cause;
    $rose(parityErrorFlag) |-> $past(popBad);
  endproperty
  a_err_cause: assert property (p_err_cause) else $error("parity flag rose without a bad word"); // RULE4

  property p_hold_on_err;
    popBad |=> (colourOut == $past(colourOut)) && (displayEnable == $past(displayEnable));
  endproperty
  a_hold_on_err: assert property (p_hold_on_err) else $error("bad word changed the output bus"); // RULE5

  property p_good_load;
    popGood |=> !parityErrorFlag && displayEnable == $past(fifoOutData[D_DEN])
      && frameSync == $past(fifoOutData[D_FSYNC]);
  endproperty
  a_good_load: assert property (p_good_load) else $error("good word not presented"); // RULE2 RULE3

  property p_err_width;
    $rose(parityErrorFlag) |-> parityErrorFlag [*8] ##1 !parityErrorFlag;
  endproperty
  a_err_width: assert property (p_err_width) else $error("parity pulse not one pixel period"); // RULE19

  property p_pclk_cause;
    $rose(pixelClk) |-> $past(fifoOutReady && fifoOutValid) ##4 $fell(pixelClk);
  endproperty
  a_pclk_cause: assert property (p_pclk_cause) else $error("pixel clock not tied to a word"); // RULE8

  property p_idle_bus;
    (state_ff.outState == OUT_OFF) |-> !pixelClk && !displayEnable && frameSync && lineSync && (&colourOut);
  endproperty
  a_idle_bus: assert property (p_idle_bus) else $error("idle bus not static"); // RULE9

  property p_shutdown;
    !rxOn |=> !state_ff.linkActive && state_ff.bitCnt == 5'd0 && !state_ff.pushValid;
  endproperty
  a_shutdown: assert property (p_shutdown) else $error("shutdown did not stop capture"); // RULE12

  property p_word_len;
    state_ff.pushValid |-> $past(state_ff.bitCnt) == $past(bitsPerLane) - 5'd1;
  endproperty
  a_word_len: assert property (p_word_len) else $error("word pushed at wrong bit count"); // RULE1 RULE11

  property p_swap;
    popGood && swapSel |=> colourOut[COLOUR_BITS-1] == $past(fifoOutData[D_COLOUR_LSB]);
  endproperty
  a_swap: assert property (p_swap) else $error("swapped colour order wrong"); // RULE10

  property p_standby;
    rxOn && state_ff.idleCnt == 12'(LINK_IDLE_CYC - 1) && !linkRise |=> !state_ff.linkActive;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby after link clock stopped"); // RULE13
endmodule

// file: bench/spd_tx_model.sv
// serializing transmitter model driving the link clock and three lanes
`timescale 1ns/1ps
module spd_tx_model (
  output logic linkClk,
  output logic laneA,
  output logic laneB,
  output logic laneC
);
  initial begin
    linkClk = 1'b0;
    laneA = 1'b0;
    laneB = 1'b1;
    laneC = 1'b0;
  end
  // payload, odd parity over payload and parity, two unused low bits
  function automatic logic [29:0] mk(input logic [26:0] p, input logic bad);
    return {p, ~^p ^ bad, 2'b00};
  endfunction
  // lanes move while the clock is low; the receiver takes them on the rising edge
  task automatic send(input logic [26:0] p, input logic bad, input int n);
    logic [29:0] w;
    w = mk(p, bad);
    #3;
    for (int k = 0; k < 30 / n; k++) begin
      #20;
      laneA = w[29 - k * n];
      laneB = (n > 1) ? w[28 - k * n] : ~laneB;
      laneC = (n > 2) ? w[27 - k * n] : ~laneC;
      #20 linkClk = 1'b1;
      #40 linkClk = 1'b0;
    end
  endtask
  // clock released and standing still; stale lane values are not left behind
  task automatic idle();
    linkClk = 1'b0;
    laneA = ~laneA;
    laneB = ~laneB;
    laneC = ~laneC;
  endtask
endmodule

// file: bench/spd_receiver_tb.sv
// self-checking bench for the serial pixel deserializer
`timescale 1ns/1ps
module spd_receiver_tb import spd_pkg::*;;
  logic ref_clk, resetn, sinkReady, psel, penable, pwrite;
  logic linkClk, laneA, laneB, laneC, pixelClk, pready, pslverr;
  logic frameSync, lineSync, displayEnable, parityErrorFlag;
  logic [23:0] colourOut;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic rdErr;
  logic pcPrev = 1'b0;
  logic [26:0] lastWord = 27'h7fffffe;
  logic [26:0] cur;
  logic [26:0] got[$];
  int failures = 0;
  int n_tests = 0;
  int cycles = 0;
  int errLen = 0;
  int nErr = 0;

  spd_tx_model i_spd_tx_model (.linkClk(linkClk), .laneA(laneA), .laneB(laneB), .laneC(laneC));
  spd_receiver #(.FIFO_DEPTH(32)) i_spd_receiver (.ref_clk(ref_clk), .resetn(resetn), .linkClk(linkClk),
    .serialLaneA(laneA), .serialLaneB(laneB), .serialLaneC(laneC), .sinkReady(sinkReady),
    .pixelClk(pixelClk), .colourOut(colourOut), .frameSync(frameSync), .lineSync(lineSync),
    .displayEnable(displayEnable), .parityErrorFlag(parityErrorFlag), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic end_of_test();
    if (failures == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // watches the pixel bus; a word held for a bad one is not collected twice
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 60000) begin
      failures++;
      end_of_test();
    end
    cur = {colourOut, frameSync, lineSync, displayEnable};
    if (parityErrorFlag === 1'b1) begin
      if (errLen == 0) check(cur, lastWord);
      errLen++;
    end else if (errLen != 0) begin
      check(errLen, 8);
      errLen = 0;
      nErr++;
    end
    if (pixelClk === 1'b1 && pcPrev !== 1'b1 && parityErrorFlag !== 1'b1) begin
      got.push_back(cur);
      lastWord = cur;
    end
    pcPrev = pixelClk;
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    rdErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [26:0] pay(input int i);
    return 27'h5a3c96b ^ 27'(i * 4663);
  endfunction

  function automatic logic [26:0] busOf(input logic [26:0] p, input logic s);
    logic [23:0] c;
    for (int b = 0; b < 24; b++) c[b] = p[26 - b];
    return s ? {c, p[2:0]} : p;
  endfunction

  task automatic waitWords(input int n);
    for (int i = 0; i < 600 && got.size() < n; i++) @(posedge ref_clk);
    repeat (150) @(posedge ref_clk);
    check(got.size(), n);
  endtask

  task automatic t_reset();
    check({colourOut, frameSync, lineSync, displayEnable}, 32'h07fffffe);
    check({pixelClk, parityErrorFlag}, 32'h0);
    apb(0, ADDR_CTRL, 32'h0);
    check(rd, CTRL_RESET);
    apb(1, 8'h0c, 32'hffffffff);
    apb(0, 8'h0c, 32'h0);
    check(rdErr, 32'h1);
    check(rd, 32'h0);
  endtask

  // every lane select code, both bus orders, two words back to back
  task automatic t_lanes();
    int n;
    for (int m = 0; m < 8; m++) begin
      n = (m[1:0] == 2'b01) ? 2 : (m[1:0] == 2'b10) ? 3 : 1;
      apb(1, ADDR_CTRL, 32'(2 * m + 1));
      apb(0, ADDR_STATUS, 32'h0);
      check(rd[5:4], n);
      got.delete();
      i_spd_tx_model.send(pay(m), 1'b0, n);
      i_spd_tx_model.send(pay(m + 8), 1'b0, n);
      i_spd_tx_model.idle();
      waitWords(2);
      check(got[0], busOf(pay(m), m[2]));
      check(got[1], busOf(pay(m + 8), m[2]));
    end
  endtask

  task automatic t_idle();
    check({colourOut, frameSync, lineSync, displayEnable}, 32'h07fffffe);
    check(pixelClk, 32'h0);
    apb(0, ADDR_STATUS, 32'h0);
    check(rd[0], 32'h0);
  endtask

  // two bad words in a row between good ones
  task automatic t_parity();
    int n0;
    apb(1, ADDR_CTRL, 32'h1);
    apb(1, ADDR_ERRCNT, 32'h0);
    n0 = nErr;
    got.delete();
    i_spd_tx_model.send(pay(30), 1'b0, 1);
    i_spd_tx_model.send(pay(31), 1'b1, 1);
    i_spd_tx_model.send(pay(32), 1'b1, 1);
    i_spd_tx_model.send(pay(33), 1'b0, 1);
    i_spd_tx_model.idle();
    waitWords(2);
    check(got[0], pay(30));
    check(got[1], pay(33));
    check(nErr - n0, 2);
    apb(0, ADDR_ERRCNT, 32'h0);
    check(rd, 32'h2);
  endtask

  task automatic t_shutdown();
    apb(1, ADDR_CTRL, 32'h0);
    apb(0, ADDR_STATUS, 32'h0);
    check(rd[1:0], 32'h2);
    got.delete();
    i_spd_tx_model.send(pay(40), 1'b0, 1);
    i_spd_tx_model.idle();
    waitWords(0);
    apb(1, ADDR_CTRL, 32'h1);
    i_spd_tx_model.send(pay(41), 1'b0, 1);
    i_spd_tx_model.idle();
    waitWords(1);
    check(got[0], pay(41));
  endtask

  // sink stalls while 34 words arrive: 32 kept, the rest dropped
  // the link keeps running while the buffer drains, since an idle link freezes the bus
  task automatic t_fifo();
    @(posedge ref_clk);
    sinkReady <= 1'b0;
    apb(1, ADDR_CTRL, 32'h5);
    got.delete();
    for (int i = 0; i < 34; i++) i_spd_tx_model.send(pay(i + 50), 1'b0, 3);
    check(got.size(), 32'h0);
    apb(0, ADDR_STATUS, 32'h0);
    check(rd[2], 32'h1);
    sinkReady <= 1'b1;
    for (int i = 0; i < 4; i++) i_spd_tx_model.send(pay(i + 90), 1'b0, 3);
    i_spd_tx_model.idle();
    waitWords(36);
    for (int i = 0; i < 36; i++) check(got[i], (i < 32) ? pay(i + 50) : pay(i + 58));
    apb(1, ADDR_STATUS, 32'h4);
    apb(0, ADDR_STATUS, 32'h0);
    check(rd[2], 32'h0);
  endtask

  initial begin
    resetn = 1'b0;
    sinkReady = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    t_reset();
    t_lanes();
    t_idle();
    t_parity();
    t_shutdown();
    t_fifo();
    end_of_test();
  end
endmodule
